// [hdl/xfer_ctrl_pkg.sv]
package xfer_ctrl_pkg;

  // sizes
  localparam int NUM_SRC  = 6;
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int REG_AW   = 8;
  localparam int REG_DW   = 16;
  localparam int EN_W     = 8;
  localparam int VEC_W    = 8;

  // register offsets on the plain register port
  localparam logic [REG_AW-1:0] EN_FIRST_OFF    = 8'h00;  // six enables, one longword apart
  localparam logic [REG_AW-1:0] EN_STEP_OFF     = 8'h04;
  localparam logic [REG_AW-1:0] CTRL_STATUS_OFF = 8'h18;
  localparam logic [REG_AW-1:0] DESC_BASE_OFF   = 8'h1c;

  // control/status fields
  localparam int CS_SW_EN_BIT = 15;
  localparam int CS_BUSY_BIT  = 14;
  localparam int CS_DONE_BIT  = 13;
  localparam int CS_VEC_LSB   = 0;
  localparam int EN_BIT       = 0;

  // mode register fields
  localparam int MODE_LSB     = 0;
  localparam int SIZE_LSB     = 2;
  localparam int SRC_INC_BIT  = 4;
  localparam int DST_INC_BIT  = 5;
  localparam int SIDE_BIT     = 6;
  localparam int IRQ_END_BIT  = 7;

  // reset values
  localparam logic [REG_DW-1:0] CS_RESET   = 16'h0000;
  localparam logic [REG_DW-1:0] BASE_RESET = 16'h0000;
  localparam logic [EN_W-1:0]   EN_RESET   = 8'h00;

  // descriptor layout in ram: four longwords, 16 bytes apart
  localparam int DESC_SHIFT = 4;
  localparam logic [1:0] DW_MODE_COUNT = 2'h0;
  localparam logic [1:0] DW_SOURCE     = 2'h1;
  localparam logic [1:0] DW_DEST       = 2'h2;
  localparam logic [1:0] DW_INITIAL    = 2'h3;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0]  ONE8  = 8'h01;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_BLOCK  = 2'b10
  } xfer_mode_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10
  } xfer_size_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b011,
    ST_BACK  = 3'b100,
    ST_DONE  = 3'b101
  } xfer_state_t;

  // one command on the on-chip bus
  typedef struct packed {
    logic              we;
    xfer_size_t        size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_cmd_t;

endpackage

// [hdl/addr_step.sv]
`timescale 1ns/1ps
`default_nettype none
module addr_step
  import xfer_ctrl_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire xfer_size_t        size,
  input  wire logic              inc,
  output logic [ADDR_W-1:0]      next_addr
);

  // advance by the unit size, or hold a fixed address
  always_comb begin
    if (!inc) begin
      next_addr = addr;
    end else begin
      case (size)
        SIZE_WORD: next_addr = addr + 32'h0000_0002;
        SIZE_LONG: next_addr = addr + 32'h0000_0004;
        default:   next_addr = addr + 32'h0000_0001;
      endcase
    end
  end

endmodule // addr_step
`default_nettype wire

// [hdl/source_select.sv]
`timescale 1ns/1ps
`default_nettype none
module source_select
  import xfer_ctrl_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] req,
  input  wire logic [NUM_SRC-1:0] enable,
  output logic                    valid,
  output logic [VEC_W-1:0]        index,
  output logic [NUM_SRC-1:0]      onehot
);

  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC:0]   lower;

  // lowest numbered enabled request wins
  assign lower[0] = 1'b0;
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign live[i]     = req[i] & enable[i];
    assign onehot[i]   = live[i] & ~lower[i];
    assign lower[i+1]  = lower[i] | live[i];
  end
  assign valid = lower[NUM_SRC];

  // encode the winner
  always_comb begin
    index = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (live[k]) begin
        index = VEC_W'(k);
      end
    end
  end

endmodule // source_select
`default_nettype wire

// [hdl/event_triggered_transfer_ctrl.sv]
// Behaviour
// R1 - normal, repeat and block modes per descriptor
// R2 - each descriptor holds 16-bit mode register
// R3 - software aligns source for word/longword
// R4 - software aligns destination for word/longword
// R5 - repeat area restart on side select
// R6 - normal mode counts 1 to 65536 transfers
// R7 - repeat: high byte reload, low byte counts
// R8 - block mode uses full 16-bit count
// R9 - second count is block length
// R10 - initial address shares block length storage
// R11 - six enable registers choose activation sources
// R12 - control/status: software start, vector, status
// R13 - base register gives descriptor upper address
// R14 - base register needs word or longword access
// R15 - working registers hidden from the cpu
// R16 - load descriptor, transfer, write it back
// R17 - software builds descriptor before enabling source
// R18 - separate descriptor per activation source
// R19 - each address fixed or incrementing
// R20 - cpu interrupt only after final count; here only with the irq_at_end mode bit set, else after every activation
// R21 - normal count decrements once per activation
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module event_triggered_transfer_ctrl
  import xfer_ctrl_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic [xfer_ctrl_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [xfer_ctrl_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [xfer_ctrl_pkg::REG_DW-1:0]   reg_rdata,
  input  wire logic                          serial_tx_empty_req,
  input  wire logic                          serial_rx_full_req,
  input  wire logic [3:0]                    other_req,
  output logic [xfer_ctrl_pkg::NUM_SRC-1:0]  src_ack,
  output logic [xfer_ctrl_pkg::NUM_SRC-1:0]  cpu_irq,
  output logic                               mem_req,
  output xfer_ctrl_pkg::mem_cmd_t            mem_cmd,
  input  wire logic                          mem_ack,
  input  wire logic [xfer_ctrl_pkg::DATA_W-1:0] mem_rdata
);
  import xfer_ctrl_pkg::*;

  // software visible registers
  logic [EN_W-1:0]   activation_enable_group [NUM_SRC];
  logic [EN_W-1:0]   next_enable [NUM_SRC];
  logic [REG_DW-1:0] xfer_ctrl_status, next_ctrl_status;
  logic [REG_DW-1:0] descriptor_base_reg, next_base;
  logic [REG_DW-1:0] next_rdata;

  // working registers, not on the register port
  logic [15:0]       xfer_mode_reg, next_mode;        // R15
  logic [ADDR_W-1:0] xfer_source_addr, next_source;
  logic [ADDR_W-1:0] xfer_dest_addr, next_dest;
  logic [ADDR_W-1:0] repeat_initial_addr, next_initial;
  logic [15:0]       xfer_count_a, next_count_a;
  logic [15:0]       units_left, next_units_left;
  logic [DATA_W-1:0] data_hold, next_data_hold;
  logic [1:0]        word_idx, next_word_idx;
  logic [VEC_W-1:0]  vector, next_vector;
  logic              from_sw, next_from_sw;
  logic              last_xfer, next_last_xfer;
  xfer_state_t       state, next_state;
  logic              next_mem_req;
  mem_cmd_t          next_mem_cmd;
  logic [NUM_SRC-1:0] next_src_ack;
  logic [NUM_SRC-1:0] next_cpu_irq;

  // descriptor field views
  logic [15:0]       block_length_reg;
  logic [7:0]        repeat_reload_count;
  logic [7:0]        repeat_running_count;
  logic [1:0]        mode_bits;
  xfer_size_t        unit_size;
  logic              repeat_side_select;
  logic              irq_at_end;
  logic [ADDR_W-1:0] desc_addr;
  logic [ADDR_W-1:0] stepped_source;
  logic [ADDR_W-1:0] stepped_dest;
  logic [NUM_SRC-1:0] req_vec;
  logic [NUM_SRC-1:0] en_vec;
  logic              sel_valid;
  logic [VEC_W-1:0]  sel_index;
  logic [NUM_SRC-1:0] sel_onehot;
  logic              en_hit;
  logic [2:0]        en_idx;

  assign block_length_reg     = repeat_initial_addr[15:0]; // R9 R10
  assign repeat_reload_count  = xfer_count_a[15:8]; // R7
  assign repeat_running_count = xfer_count_a[7:0]; // R7
  assign mode_bits            = xfer_mode_reg[MODE_LSB +: 2]; // R1 R2
  assign unit_size            = xfer_size_t'(xfer_mode_reg[SIZE_LSB +: 2]);
  assign repeat_side_select   = xfer_mode_reg[SIDE_BIT];
  assign irq_at_end           = xfer_mode_reg[IRQ_END_BIT];
  assign desc_addr = {descriptor_base_reg, 16'h0000}
                     + (ADDR_W'(vector) << DESC_SHIFT); // R13 R18

  assign req_vec = {other_req, serial_rx_full_req, serial_tx_empty_req};

  // enable bit of each source
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      en_vec[i] = activation_enable_group[i][EN_BIT]; // R11
    end
  end

  // pick the requesting source
  source_select u_select (
    .req    (req_vec),
    .enable (en_vec),
    .valid  (sel_valid),
    .index  (sel_index),
    .onehot (sel_onehot)
  );

  // address advance after each unit
  addr_step u_src_step (
    .addr      (xfer_source_addr),
    .size      (unit_size),
    .inc       (xfer_mode_reg[SRC_INC_BIT]),
    .next_addr (stepped_source)
  );

  addr_step u_dst_step (
    .addr      (xfer_dest_addr),
    .size      (unit_size),
    .inc       (xfer_mode_reg[DST_INC_BIT]),
    .next_addr (stepped_dest)
  );

  // decode of the six enable registers
  always_comb begin
    en_hit = 1'b0;
    en_idx = 3'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (reg_addr == EN_FIRST_OFF + REG_AW'(i) * EN_STEP_OFF) begin
        en_hit = 1'b1;
        en_idx = 3'(i);
      end
    end
  end

  // register port: writes, status and read data
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      next_enable[i] = activation_enable_group[i];
    end
    next_ctrl_status = xfer_ctrl_status;
    next_base        = descriptor_base_reg;
    next_rdata       = '0;
    if (reg_wr) begin
      if (en_hit) begin
        next_enable[en_idx] = reg_wdata[EN_W-1:0]; // R11
      end else if (reg_addr == CTRL_STATUS_OFF) begin
        next_ctrl_status[CS_SW_EN_BIT] = reg_wdata[CS_SW_EN_BIT]; // R12
        next_ctrl_status[CS_VEC_LSB +: VEC_W] = reg_wdata[CS_VEC_LSB +: VEC_W];
        if (reg_wdata[CS_DONE_BIT]) begin
          next_ctrl_status[CS_DONE_BIT] = 1'b0; // write one clears
        end
      end else if (reg_addr == DESC_BASE_OFF) begin
        next_base = reg_wdata; // R13 R14
      end
    end
    // finished descriptor turns its source off, over a write
    if (state == ST_DONE && last_xfer && !from_sw) begin
      next_enable[vector[2:0]][EN_BIT] = 1'b0; // R21
    end
    // hardware side of control/status, wins over a register write
    if (state == ST_DONE && from_sw) begin
      next_ctrl_status[CS_SW_EN_BIT] = 1'b0;
      next_ctrl_status[CS_DONE_BIT]  = 1'b1; // R12
    end
    next_ctrl_status[CS_BUSY_BIT] = (next_state != ST_IDLE);          // R12
    if (reg_rd) begin
      if (en_hit) begin
        next_rdata = {8'h00, activation_enable_group[en_idx]};
      end else if (reg_addr == CTRL_STATUS_OFF) begin
        next_rdata = xfer_ctrl_status;
      end else if (reg_addr == DESC_BASE_OFF) begin
        next_rdata = descriptor_base_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        activation_enable_group[i] <= EN_RESET;
      end
      xfer_ctrl_status    <= CS_RESET;
      descriptor_base_reg <= BASE_RESET;
      reg_rdata           <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        activation_enable_group[i] <= next_enable[i];
      end
      xfer_ctrl_status    <= next_ctrl_status;
      descriptor_base_reg <= next_base;
      reg_rdata           <= next_rdata;
    end
  end

  // transfer sequencer: fetch, move, write back, report
  always_comb begin
    next_state      = state;
    next_mode       = xfer_mode_reg;
    next_source     = xfer_source_addr;
    next_dest       = xfer_dest_addr;
    next_initial    = repeat_initial_addr;
    next_count_a    = xfer_count_a;
    next_units_left = units_left;
    next_data_hold  = data_hold;
    next_word_idx   = word_idx;
    next_vector     = vector;
    next_from_sw    = from_sw;
    next_last_xfer  = last_xfer;
    next_mem_req    = 1'b0;
    next_mem_cmd    = mem_cmd;
    next_src_ack    = '0;
    next_cpu_irq    = '0;
    case (state)
      ST_IDLE: begin
        if (sel_valid || xfer_ctrl_status[CS_SW_EN_BIT]) begin
          next_from_sw  = !sel_valid;
          next_vector   = sel_valid ? sel_index
                                    : xfer_ctrl_status[CS_VEC_LSB +: VEC_W]; // R12
          next_src_ack  = sel_onehot;
          next_word_idx = DW_MODE_COUNT;
          next_state    = ST_FETCH;
          next_mem_req  = 1'b1; // R16
          next_mem_cmd  = '{we: 1'b0, size: SIZE_LONG, wdata: '0,
                            addr: {descriptor_base_reg, 16'h0000}
                                  + (ADDR_W'(next_vector) << DESC_SHIFT)};
        end
      end
      ST_FETCH: begin
        if (mem_ack) begin
          case (word_idx)
            DW_MODE_COUNT: begin
              next_mode    = mem_rdata[31:16]; // R2
              next_count_a = mem_rdata[15:0];
            end
            DW_SOURCE: next_source = mem_rdata;
            DW_DEST:   next_dest   = mem_rdata;
            default:   next_initial = mem_rdata;
          endcase
          next_mem_req = 1'b1;
          if (word_idx == DW_INITIAL) begin
            // block mode moves a whole block per activation
            next_units_left = (mode_bits == MODE_BLOCK) ? mem_rdata[15:0] : ONE16; // R8 R9
            next_state      = ST_READ;
            next_mem_cmd    = '{we: 1'b0, size: unit_size, wdata: '0,
                                addr: xfer_source_addr}; // R3
          end else begin
            next_word_idx     = word_idx + 2'h1;
            next_mem_cmd.addr = mem_cmd.addr + 32'h0000_0004;
          end
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          next_data_hold = mem_rdata;
          next_state     = ST_WRITE;
          next_mem_req   = 1'b1;
          next_mem_cmd   = '{we: 1'b1, size: unit_size, wdata: mem_rdata,
                             addr: xfer_dest_addr}; // R4
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          next_source  = stepped_source; // R19
          next_dest    = stepped_dest; // R19
          next_mem_req = 1'b1;
          if (units_left != ONE16 && units_left != 16'h0000) begin
            next_units_left = units_left - ONE16;
            next_state      = ST_READ;
            next_mem_cmd    = '{we: 1'b0, size: unit_size, wdata: '0,
                                addr: stepped_source};
          end else begin
            if (mode_bits == MODE_REPEAT) begin
              next_last_xfer = 1'b0;
              if (repeat_running_count == ONE8) begin
                next_count_a = {repeat_reload_count, repeat_reload_count}; // R7
                if (repeat_side_select) begin
                  next_source = repeat_initial_addr; // R5
                end else begin
                  next_dest = repeat_initial_addr; // R5
                end
              end else begin
                next_count_a = {repeat_reload_count, repeat_running_count - ONE8}; // R7
              end
            end else begin
              // zero in the counter stands for 65536 transfers
              next_last_xfer = (xfer_count_a == ONE16); // R6 R21
              next_count_a   = xfer_count_a - ONE16; // R6 R8 R21
            end
            next_word_idx = DW_MODE_COUNT;
            next_state    = ST_BACK;
            next_mem_cmd  = '{we: 1'b1, size: SIZE_LONG,
                              wdata: {xfer_mode_reg, next_count_a},
                              addr: desc_addr}; // R16
          end
        end
      end
      ST_BACK: begin
        if (mem_ack) begin
          if (word_idx == DW_INITIAL) begin
            next_state = ST_DONE;
          end else begin
            next_word_idx     = word_idx + 2'h1;
            next_mem_req      = 1'b1;
            next_mem_cmd.addr = mem_cmd.addr + 32'h0000_0004;
            case (next_word_idx)
              DW_SOURCE: next_mem_cmd.wdata = xfer_source_addr;
              DW_DEST:   next_mem_cmd.wdata = xfer_dest_addr;
              default:   next_mem_cmd.wdata = repeat_initial_addr;
            endcase
          end
        end
      end
      ST_DONE: begin
        // per-activation interrupt, held back until the final count only when irq_at_end is set
        if (!from_sw && (!irq_at_end || last_xfer)) begin
          next_cpu_irq[vector[2:0]] = 1'b1; // R20
        end
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state               <= ST_IDLE;
      xfer_mode_reg       <= '0;
      xfer_source_addr    <= '0;
      xfer_dest_addr      <= '0;
      repeat_initial_addr <= '0;
      xfer_count_a        <= '0;
      units_left          <= '0;
      data_hold           <= '0;
      word_idx            <= DW_MODE_COUNT;
      vector              <= '0;
      from_sw             <= 1'b0;
      last_xfer           <= 1'b0;
      mem_req             <= 1'b0;
      mem_cmd             <= '0;
      src_ack             <= '0;
      cpu_irq             <= '0;
    end else begin
      state               <= next_state;
      xfer_mode_reg       <= next_mode;
      xfer_source_addr    <= next_source;
      xfer_dest_addr      <= next_dest;
      repeat_initial_addr <= next_initial;
      xfer_count_a        <= next_count_a;
      units_left          <= next_units_left;
      data_hold           <= next_data_hold;
      word_idx            <= next_word_idx;
      vector              <= next_vector;
      from_sw             <= next_from_sw;
      last_xfer           <= next_last_xfer;
      mem_req             <= next_mem_req;
      mem_cmd             <= next_mem_cmd;
      src_ack             <= next_src_ack;
      cpu_irq             <= next_cpu_irq;
    end
  end

endmodule // event_triggered_transfer_ctrl
`default_nettype wire

// [test/xfer_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module xfer_mem_model (
  input  wire logic                       clk,
  input  wire logic                       mem_req,
  input  wire xfer_ctrl_pkg::mem_cmd_t    mem_cmd,
  input  wire logic [3:0]                 lat,
  output logic                            mem_ack,
  output logic [xfer_ctrl_pkg::DATA_W-1:0] mem_rdata
);
  import xfer_ctrl_pkg::*;
  logic [7:0]        mem [0:255];
  mem_cmd_t          cmd;
  logic              busy;
  int                cnt;
  logic [DATA_W-1:0] r;
  // ram and the ack and read data start cleared
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    busy = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = '0;
  end
  // one command at a time, acked lat+1 cycles after the request is taken
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // no stale data outside an answer
    if (mem_req) begin
      cmd = mem_cmd;
      busy = 1'b1;
      cnt = lat;
    end else if (busy && cnt > 0) begin
      cnt--;
    end else if (busy) begin
      busy = 1'b0;
      r = '0;
      // byte lanes per size, right aligned
      for (int i = 0; i < (1 << cmd.size); i++) begin
        if (cmd.we) mem[8'(cmd.addr[7:0] + i)] = cmd.wdata[8*i +: 8];
        r[8*i +: 8] = mem[8'(cmd.addr[7:0] + i)];
      end
      mem_ack <= 1'b1;
      mem_rdata <= cmd.we ? ~mem_rdata : r;
    end
  end
endmodule // xfer_mem_model
`default_nettype wire

// [test/event_triggered_transfer_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module xfer_ctrl_asserts (
  input wire logic                          clk,
  input wire logic                          rstn,
  input wire logic [xfer_ctrl_pkg::REG_AW-1:0] reg_addr,
  input wire logic [xfer_ctrl_pkg::REG_DW-1:0] reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [xfer_ctrl_pkg::REG_DW-1:0] reg_rdata,
  input wire logic                          serial_tx_empty_req,
  input wire logic                          serial_rx_full_req,
  input wire logic [3:0]                    other_req,
  input wire logic [xfer_ctrl_pkg::NUM_SRC-1:0] src_ack,
  input wire logic [xfer_ctrl_pkg::NUM_SRC-1:0] cpu_irq,
  input wire logic                          mem_req,
  input wire xfer_ctrl_pkg::mem_cmd_t       mem_cmd,
  input wire logic                          mem_ack,
  input wire logic [xfer_ctrl_pkg::DATA_W-1:0] mem_rdata
);
  import xfer_ctrl_pkg::*;
  logic        outst;
  logic [15:0] base_copy;
  // outstanding command, base as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outst <= 1'b0;
      base_copy <= BASE_RESET;
    end else begin
      outst <= mem_req | (outst & ~mem_ack);
      if (reg_wr && reg_addr == DESC_BASE_OFF) base_copy <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ack_onehot_a: assert property (src_ack != '0 |-> $onehot(src_ack))
    else $error("src_ack not one-hot");
  fetch_start_a: assert property (src_ack != '0 |-> mem_req && !mem_cmd.we
    && mem_cmd.addr[31:16] == base_copy && mem_cmd.addr[3:0] == 4'h0)
    else $error("no descriptor fetch");
  one_outstanding_a: assert property (mem_req |-> !outst)
    else $error("second outstanding command");
  req_pulse_a: assert property (mem_req |=> !mem_req)
    else $error("mem_req too long");
  cmd_hold_a: assert property (outst && !mem_req |-> $stable(mem_cmd))
    else $error("mem_cmd moved");
  irq_after_back_a: assert property (cpu_irq != '0 |-> $past(mem_ack, 2))
    else $error("cpu_irq misplaced");
  irq_pulse_a: assert property (cpu_irq != '0 |=> cpu_irq == '0)
    else $error("cpu_irq too long");
  base_read_a: assert property (reg_rd && reg_addr == DESC_BASE_OFF |=> reg_rdata == base_copy)
    else $error("base read wrong");
  enable_width_a: assert property (reg_rd && reg_addr < CTRL_STATUS_OFF |=> reg_rdata[15:8] == 8'h00)
    else $error("enable upper bits set");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("stray read data");
  irq_seen_c: cover property (cpu_irq != '0);
  rx_taken_c: cover property (src_ack[1]);
  write_back_c: cover property (mem_req && mem_cmd.we);
endmodule // xfer_ctrl_asserts
bind event_triggered_transfer_ctrl xfer_ctrl_asserts u_chk (.clk(clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .serial_tx_empty_req(serial_tx_empty_req),
  .serial_rx_full_req(serial_rx_full_req), .other_req(other_req), .src_ack(src_ack),
  .cpu_irq(cpu_irq), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata));
`default_nettype wire

// [test/test_event_triggered_transfer_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_event_triggered_transfer_ctrl;
  import xfer_ctrl_pkg::*;
  logic              clk, rstn, reg_wr, reg_rd, mem_req, mem_ack, irq_seen;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata, rd;
  logic [5:0]        reqs, src_ack, cpu_irq;
  logic [3:0]        lat;
  logic [DATA_W-1:0] mem_rdata;
  mem_cmd_t          mem_cmd;
  int                failures, check_count;
  event_triggered_transfer_ctrl dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_tx_empty_req(reqs[0]), .serial_rx_full_req(reqs[1]), .other_req(reqs[5:2]),
    .src_ack(src_ack), .cpu_irq(cpu_irq), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  xfer_mem_model mdl (.clk(clk), .mem_req(mem_req), .mem_cmd(mem_cmd), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic put32(input int a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) mdl.mem[a+i] = v[8*i +: 8];
  endtask
  function automatic logic [31:0] get32(input int a);
    return {mdl.mem[a+3], mdl.mem[a+2], mdl.mem[a+1], mdl.mem[a]};
  endfunction
  // descriptor in ram before enable
  task automatic desc(input int v, input logic [15:0] m, c, input logic [31:0] s, d, i);
    put32(16*v, {m, c});
    put32(16*v+4, s);
    put32(16*v+8, d);
    put32(16*v+12, i);
  endtask
  // one activation and its irq window
  task automatic activate(input int s, input int units);
    int n;
    n = 0;
    irq_seen = 1'b0;
    @(posedge clk);
    reqs[s] <= 1'b1;
    do begin @(posedge clk); #1 n++; end while (src_ack[s] !== 1'b1 && n < 50);
    @(posedge clk);
    reqs[s] <= 1'b0;
    repeat (8 + 2*units) begin
      do begin @(posedge clk); #1 n++; end while (mem_ack !== 1'b1 && n < 400);
    end
    repeat (4) begin @(posedge clk); #1 irq_seen |= cpu_irq[s]; end
    chk(32'(n < 400), 1, "activation hung");
  endtask
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin rdr(8'(4*i)); chk(rd, 0, "enable reset"); end
    rdr(8'h18); chk(rd, 0, "ctrl reset");
    rdr(8'h1c); chk(rd, 0, "base reset");
    wr(8'h1c, 16'h2a5c); rdr(8'h1c); chk(rd, 16'h2a5c, "base rw");
    wr(8'h20, 16'hffff); rdr(8'h20); chk(rd, 0, "unmapped");
  endtask
  task automatic t_tx;
    desc(0, 16'h0090, 16'h0003, 32'h90, 32'ha0, 0);
    put32(32'h90, 32'h00c3b2a1);
    wr(8'h00, 16'h0001);
    lat = 4'd2;
    for (int i = 0; i < 3; i++) begin
      activate(0, 1);
      chk(mdl.mem[8'ha0], 8'ha1 + 8'h11*i, "tx byte");
      chk(get32(0), {16'h0090, 16'(2 - i)}, "tx count");
      chk(irq_seen, i == 2, "tx irq");
    end
    chk(get32(4), 32'h93, "tx source");
    rdr(8'h00); chk(rd, 0, "tx enable");
  endtask
  task automatic t_rx;
    desc(1, 16'h0020, 16'h0002, 32'ha4, 32'hb0, 0);
    wr(8'h04, 16'h0001);
    lat = 4'd0;
    for (int i = 0; i < 2; i++) begin
      mdl.mem[8'ha4] = 8'h5a + 8'(i);
      activate(1, 1);
      chk(mdl.mem[8'hb0 + i], 8'h5a + 8'(i), "rx byte");
      chk(irq_seen, 1, "rx irq");
    end
    chk(get32(24), 32'hb2, "rx dest");
  endtask
  task automatic t_rep;
    desc(2, 16'h0021, 16'h0202, 32'ha8, 32'hc0, 32'hc0);
    wr(8'h08, 16'h0001);
    lat = 4'd1;
    for (int i = 0; i < 3; i++) begin
      mdl.mem[8'ha8] = 8'h10 + 8'(i);
      activate(2, 1);
    end
    chk(mdl.mem[8'hc0], 8'h12, "repeat wrap");
    chk(mdl.mem[8'hc1], 8'h11, "repeat second");
    chk(get32(32), {16'h0021, 16'h0201}, "repeat count");
    chk(get32(40), 32'hc1, "repeat dest");
    rdr(8'h08); chk(rd, 1, "repeat enable");
    wr(8'h08, 16'h0000);
  endtask
  task automatic t_blk;
    desc(3, 16'h0032, 16'h0001, 32'hd0, 32'he0, 32'h3);
    put32(32'hd0, 32'h00332211);
    wr(8'h0c, 16'h0001);
    lat = 4'd3;
    activate(3, 3);
    for (int i = 0; i < 3; i++) chk(mdl.mem[8'he0 + i], 8'h11 * (i + 1), "block byte");
    chk(get32(48), {16'h0032, 16'h0000}, "block count");
    chk(irq_seen, 1, "block irq");
  endtask
  task automatic t_sw;
    int n;
    desc(4, 16'h0008, 16'h0001, 32'hf0, 32'hf8, 0);
    put32(32'hf0, 32'h13572468);
    wr(8'h18, 16'h8004);
    n = 0;
    do begin rdr(8'h18); n++; end while (rd[13] !== 1'b1 && n < 100);
    chk(rd, 16'h2004, "sw status");
    chk(get32(32'hf8), 32'h13572468, "sw long copy");
    wr(8'h18, 16'h2004); rdr(8'h18); chk(rd, 16'h0004, "sw done clear");
  endtask
  initial begin
    failures = 0;
    check_count = 0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reqs = '0;
    lat = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_rep;
    t_blk;
    t_sw;
    print_verdict;
  end
  // watchdog
  initial begin
    #100us;
    failures++;
    print_verdict;
  end
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
endmodule // test_event_triggered_transfer_ctrl
`default_nettype wire
